// ### vol_regs_pkg.sv
// Shared constants and types for the volume, mute and analog control slice
`default_nettype none
package vol_regs_pkg;

    // ------------------------------------------------------------------
    // Register addresses on the control port
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_VOL_CFG     = 8'h03;
    localparam logic [7:0] ADDR_LEFT_GAIN   = 8'h04;
    localparam logic [7:0] ADDR_RIGHT_GAIN  = 8'h05;
    localparam logic [7:0] ADDR_ANALOG_CTRL = 8'h06;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int FADE_BIT       = 7;
    localparam int MUTE_RIGHT_BIT = 1;
    localparam int MUTE_LEFT_BIT  = 0;
    localparam int BRIDGE_BIT     = 7;
    localparam int RATE_HI        = 6;
    localparam int RATE_LO        = 4;
    localparam int AGAIN_HI       = 3;
    localparam int AGAIN_LO       = 2;
    localparam int SRC_CH_BIT     = 1;

    localparam logic [7:0] VOL_CFG_RESET   = 8'h80;
    localparam logic [7:0] VOL_CFG_WMASK   = 8'h83;
    localparam logic [7:0] GAIN_RESET      = 8'hcf;
    localparam logic [7:0] GAIN_MIN_VALID  = 8'h07;
    localparam logic [7:0] ANALOG_RESET    = 8'h51;
    localparam logic [1:0] AGAIN_FORBIDDEN = 2'h3;

    // Switching rate multiples of the word clock, indexed by rate code
    localparam logic [4:0] RATE_MULT [8] = '{
        5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18
    };

    // ------------------------------------------------------------------
    // Fade timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 25;
    localparam int FADE_STEP_NS     = 10000;
    localparam int FADE_STEP_CYCLES = FADE_STEP_NS / CLK_PERIOD_NS;
    localparam logic [8:0] FADE_CNT_LAST = 9'(FADE_STEP_CYCLES - 1);

    // ------------------------------------------------------------------
    // Control port request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } ctrl_req_t;

endpackage
`default_nettype wire

// ### volume_mute_analog_ctrl_regs.sv
// Volume, soft mute, fade and analog control register slice
`default_nettype none
module volume_mute_analog_ctrl_regs (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_reset,
    input  wire vol_regs_pkg::ctrl_req_t i_req,
    input  wire logic                    i_double_speed,
    output logic [7:0]                   o_rd_data,
    output logic [7:0]                   o_left_gain_code,
    output logic [7:0]                   o_right_gain_code,
    output logic                         o_mute_left,
    output logic                         o_mute_right,
    output logic                         o_parallel_bridge_select,
    output logic                         o_parallel_source_channel,
    output logic [1:0]                   o_analog_gain,
    output logic [4:0]                   o_switch_mult
);
    import vol_regs_pkg::*;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] target_reg [2];
    logic [7:0] target_next [2];
    logic [7:0] analog_reg, analog_next;
    logic [7:0] rd_reg, rd_next;

    always_comb begin
        cfg_next       = cfg_reg;
        target_next[0] = target_reg[0];
        target_next[1] = target_reg[1];
        analog_next    = analog_reg;
        rd_next        = rd_reg;
        if (i_req.wr) begin
            case (i_req.addr)
                ADDR_VOL_CFG: begin
                    // Reserved bits are not stored
                    cfg_next = i_req.data & VOL_CFG_WMASK;
                end
                ADDR_LEFT_GAIN: begin
                    target_next[0] = i_req.data;
                end
                ADDR_RIGHT_GAIN: begin
                    target_next[1] = i_req.data;
                end
                ADDR_ANALOG_CTRL: begin
                    analog_next = i_req.data;
                    // A forbidden gain code keeps the old setting
                    if (i_req.data[AGAIN_HI:AGAIN_LO] == AGAIN_FORBIDDEN) begin
                        analog_next[AGAIN_HI:AGAIN_LO] =
                            analog_reg[AGAIN_HI:AGAIN_LO];
                    end
                end
                default: begin
                end
            endcase
        end
        if (i_req.rd) begin
            case (i_req.addr)
                ADDR_VOL_CFG:     rd_next = cfg_reg;
                ADDR_LEFT_GAIN:   rd_next = target_reg[0];
                ADDR_RIGHT_GAIN:  rd_next = target_reg[1];
                ADDR_ANALOG_CTRL: rd_next = analog_reg;
                default:          rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cfg_reg       <= VOL_CFG_RESET;
            target_reg[0] <= GAIN_RESET;
            target_reg[1] <= GAIN_RESET;
            analog_reg    <= ANALOG_RESET;
            rd_reg        <= 8'h00;
        end else begin
            cfg_reg       <= cfg_next;
            target_reg[0] <= target_next[0];
            target_reg[1] <= target_next[1];
            analog_reg    <= analog_next;
            rd_reg        <= rd_next;
        end
    end

    // ------------------------------------------------------------------
    // Fade step timer
    // ------------------------------------------------------------------
    logic [8:0] step_cnt_reg, step_cnt_next;
    logic       step_tick;

    always_comb begin
        step_tick     = (step_cnt_reg == FADE_CNT_LAST);
        step_cnt_next = step_tick ? 9'h000 : step_cnt_reg + 9'h001;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            step_cnt_reg <= 9'h000;
        end else begin
            step_cnt_reg <= step_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Per channel applied gain and mute (0 = left, 1 = right)
    // ------------------------------------------------------------------
    logic [7:0] applied_reg [2];
    logic       mute_reg [2];
    logic       fade_en;

    assign fade_en = cfg_reg[FADE_BIT];

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [7:0] applied_next;
        logic       mute_next;
        logic       soft_mute;

        assign soft_mute = (ch == 0) ? cfg_reg[MUTE_LEFT_BIT]
                                     : cfg_reg[MUTE_RIGHT_BIT];

        // Each code step is one 0.5 dB gain step, so a fade walks codes
        always_comb begin
            applied_next = applied_reg[ch];
            if (!fade_en) begin
                applied_next = target_reg[ch];
            end else if (step_tick) begin
                if (applied_reg[ch] < target_reg[ch]) begin
                    applied_next = applied_reg[ch] + 8'h01;
                end else if (applied_reg[ch] > target_reg[ch]) begin
                    applied_next = applied_reg[ch] - 8'h01;
                end
            end
            // Below the -100 dB code the channel is silenced
            mute_next = soft_mute
                      | (applied_reg[ch] < GAIN_MIN_VALID);
        end

        always_ff @(posedge i_sys_clk) begin
            if (i_reset) begin
                applied_reg[ch] <= GAIN_RESET;
                mute_reg[ch]    <= 1'b0;
            end else begin
                applied_reg[ch] <= applied_next;
                mute_reg[ch]    <= mute_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Analog side decode
    // ------------------------------------------------------------------
    logic [4:0] mult_reg, mult_next;
    logic [4:0] base_mult;

    always_comb begin
        base_mult = RATE_MULT[analog_reg[RATE_HI:RATE_LO]];
        // Every listed multiple is even, so halving stays exact
        mult_next = i_double_speed ? (base_mult >> 1) : base_mult;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            // Same multiple that the analog reset value selects
            mult_reg <= RATE_MULT[ANALOG_RESET[RATE_HI:RATE_LO]];
        end else begin
            mult_reg <= mult_next;
        end
    end

    assign o_rd_data                 = rd_reg;
    assign o_left_gain_code          = applied_reg[0];
    assign o_right_gain_code         = applied_reg[1];
    assign o_mute_left               = mute_reg[0];
    assign o_mute_right              = mute_reg[1];
    assign o_parallel_bridge_select  = analog_reg[BRIDGE_BIT];
    assign o_parallel_source_channel = analog_reg[SRC_CH_BIT];
    assign o_analog_gain             = analog_reg[AGAIN_HI:AGAIN_LO];
    assign o_switch_mult             = mult_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    chk_cfg_reserved_zero: assert property (
        i_req.rd && i_req.addr == ADDR_VOL_CFG |=> o_rd_data[6:2] == 5'h00)
        else $error("reserved config bits read nonzero");
    chk_fade_reset_one: assert property (
        $past(i_reset) |-> fade_en && applied_reg[0] == applied_reg[1])
        else $error("fade enable not set after reset");
    chk_gain_reset_val: assert property (
        $past(i_reset) |-> target_reg[0] == 8'hcf && target_reg[1] == 8'hcf)
        else $error("gain codes not at 0 dB after reset");
    chk_mute_right_out: assert property (
        cfg_reg[MUTE_RIGHT_BIT] |=> o_mute_right)
        else $error("right soft mute not applied");
    chk_mute_left_out: assert property (
        cfg_reg[MUTE_LEFT_BIT] |=> o_mute_left)
        else $error("left soft mute not applied");
    chk_left_write_read: assert property (
        i_req.wr && !i_req.rd && i_req.addr == ADDR_LEFT_GAIN
        ##1 !i_req.wr
        ##1 i_req.rd && i_req.addr == ADDR_LEFT_GAIN && !i_req.wr
        |=> o_rd_data == $past(i_req.data, 3))
        else $error("left gain readback mismatch");
    chk_right_write: assert property (
        i_req.wr && i_req.addr == ADDR_RIGHT_GAIN
        |=> target_reg[1] == $past(i_req.data))
        else $error("right gain code not stored");
    chk_nofade_jump: assert property (
        !fade_en && !i_req.wr ##1 !fade_en
        |-> o_left_gain_code == $past(target_reg[0]))
        else $error("unfaded gain did not jump to target");
    chk_low_code_mute: assert property (
        o_left_gain_code < 8'h07 |=> o_mute_left)
        else $error("code below minimum did not mute");
    chk_fade_one_step: assert property (
        fade_en && step_tick && o_left_gain_code < target_reg[0]
        |=> o_left_gain_code == $past(o_left_gain_code) + 8'h01
            ##1 $stable(o_left_gain_code))
        else $error("fade step not exactly one code");
    chk_gain_refused: assert property (
        i_req.wr && i_req.addr == ADDR_ANALOG_CTRL
        && i_req.data[3:2] == 2'h3 |=> o_analog_gain == $past(o_analog_gain))
        else $error("forbidden analog gain code accepted");
    chk_rate_decode: assert property (
        analog_reg[6:4] == 3'h7 && i_double_speed |=> o_switch_mult == 5'h0c)
        else $error("double speed rate not halved");
    chk_mode_write: assert property (
        i_req.wr && i_req.addr == ADDR_ANALOG_CTRL && i_req.data[3:2] != 2'h3
        |=> analog_reg == $past(i_req.data))
        else $error("analog control not stored");

    cov_fade_down: cover property (
        fade_en && step_tick && o_right_gain_code > target_reg[1]);
    cov_code_mute: cover property (o_right_gain_code < 8'h07 ##1 o_mute_right);
    cov_parallel_left: cover property (
        o_parallel_bridge_select && o_parallel_source_channel);
    cov_gain_refused: cover property (
        i_req.wr && i_req.addr == ADDR_ANALOG_CTRL && i_req.data[3:2] == 2'h3);

endmodule
`default_nettype wire

// ### host_ctrl_model.sv
// Host controller model issuing single-byte control-port accesses
`default_nettype none
module host_ctrl_model
    import vol_regs_pkg::*;
(
    input  wire logic                    i_sys_clk,
    output var  vol_regs_pkg::ctrl_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, data: 8'h00};

    // One strobe cycle per byte; idle lines carry the inverse of the last
    // byte so a stale value is never taken for a live one. Field values are
    // what the bench commands, it alone breaks them on purpose
    task automatic access(input logic       wr,
                          input logic [7:0] addr,
                          input logic [7:0] data);
        @(negedge i_sys_clk);
        o_req = '{wr: wr, rd: !wr, addr: addr, data: data};
        @(negedge i_sys_clk);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the volume, mute and analog register slice
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import vol_regs_pkg::*;

    logic       sys_clk, reset, double_speed;
    ctrl_req_t  req;
    logic [7:0] rd_data, left_gain, right_gain;
    logic       mute_left, mute_right, bridge, source;
    logic [1:0] analog_gain;
    logic [4:0] switch_mult;
    int         err_total = 0;
    int         tests_run = 0;
    int         mult_tab [8] = '{6, 8, 10, 12, 14, 16, 20, 24};

    host_ctrl_model host_ctrl_model_i (.i_sys_clk(sys_clk), .o_req(req));

    volume_mute_analog_ctrl_regs volume_mute_analog_ctrl_regs_i (
        .i_sys_clk                 (sys_clk),
        .i_reset                   (reset),
        .i_req                     (req),
        .i_double_speed            (double_speed),
        .o_rd_data                 (rd_data),
        .o_left_gain_code          (left_gain),
        .o_right_gain_code         (right_gain),
        .o_mute_left               (mute_left),
        .o_mute_right              (mute_right),
        .o_parallel_bridge_select  (bridge),
        .o_parallel_source_channel (source),
        .o_analog_gain             (analog_gain),
        .o_switch_mult             (switch_mult)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic put(input logic [7:0] addr, input logic [7:0] data);
        host_ctrl_model_i.access(1'b1, addr, data);
    endtask

    // Write lands at c1, applied code at c2, mute at c3
    task automatic settle();
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp,
                            input string what);
        host_ctrl_model_i.access(1'b0, addr, 8'h00);
        @(negedge sys_clk);
        check(what, rd_data, exp);
    endtask

    task automatic test_done();
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_values();
        reg_read(ADDR_VOL_CFG, 8'h80, "cfg");
        reg_read(ADDR_LEFT_GAIN, 8'hcf, "left");
        reg_read(ADDR_RIGHT_GAIN, 8'hcf, "right");
        reg_read(ADDR_ANALOG_CTRL, 8'h51, "analog");
        reg_read(8'h07, 8'h00, "unmapped");
        check("mult", 8'(switch_mult), 8'h10);
        check("again", 8'(analog_gain), 8'h00);
        check("lcode", left_gain, 8'hcf);
    endtask

    task automatic mute_bits();
        put(ADDR_VOL_CFG, 8'hfe);
        settle();
        reg_read(ADDR_VOL_CFG, 8'h82, "cfg_ro");
        check("mute_r", 8'(mute_right), 8'h01);
        check("mute_l", 8'(mute_left), 8'h00);
        put(ADDR_VOL_CFG, 8'h01);
        settle();
        check("mute_r", 8'(mute_right), 8'h00);
        check("mute_l", 8'(mute_left), 8'h01);
        put(ADDR_VOL_CFG, 8'h00);
        settle();
    endtask

    task automatic gain_codes();
        logic [7:0] codes [4] = '{8'h06, 8'h07, 8'hff, 8'h00};
        foreach (codes[k]) begin
            put(ADDR_RIGHT_GAIN, ~codes[k]);
            put(ADDR_LEFT_GAIN, codes[k]);
            reg_read(ADDR_LEFT_GAIN, codes[k], "lread");
            settle();
            check("lcode", left_gain, codes[k]);
            check("rcode", right_gain, ~codes[k]);
            check("lmute", 8'(mute_left), 8'(codes[k] < 8'h07));
            check("rmute", 8'(mute_right), 8'(~codes[k] < 8'h07));
            reg_read(ADDR_RIGHT_GAIN, ~codes[k], "rread");
        end
    endtask

    task automatic analog_fields();
        logic [7:0] val;
        for (int c = 0; c < 16; c++) begin
            val = {c[0], 3'(c % 8), 2'(c % 3), c[1], 1'b1};
            double_speed = c[3];
            put(ADDR_ANALOG_CTRL, val);
            settle();
            check("mult", 8'(switch_mult),
                  8'(mult_tab[c % 8] >> c[3]));
            check("bridge", 8'(bridge), 8'(c[0]));
            check("source", 8'(source), 8'(c[1]));
            check("again", 8'(analog_gain), 8'(c % 3));
            reg_read(ADDR_ANALOG_CTRL, val, "analog");
        end
        put(ADDR_ANALOG_CTRL, 8'hfd);
        settle();
        check("again_kept", 8'(analog_gain), 8'h00);
        check("source_taken", 8'(source), 8'h00);
    endtask

    // Fade walks the applied code one step per tick; tick phase is free
    // running, so only the spacing between steps is pinned down
    task automatic fade_steps();
        logic [7:0] prev;
        int         last, steps;
        put(ADDR_LEFT_GAIN, 8'h05);
        settle();
        put(ADDR_VOL_CFG, 8'h80);
        put(ADDR_LEFT_GAIN, 8'h08);
        prev = left_gain;
        last = -1;
        steps = 0;
        for (int n = 0; n < 1300 && prev !== 8'h08; n++) begin
            @(negedge sys_clk);
            if (left_gain !== prev) begin
                check("step", left_gain, prev + 8'h01);
                if (last >= 0) begin
                    check("gap", 8'(n - last == FADE_STEP_CYCLES),
                          8'h01);
                end
                last = n;
                steps++;
                prev = left_gain;
            end
        end
        settle();
        check("steps", 8'(steps), 8'h03);
        check("lmute", 8'(mute_left), 8'h00);
        check("rcode", right_gain, 8'hff);
    endtask

    // Mid-run reset must bring every register back to its reset value
    task automatic reset_again();
        reset = 1'b1;
        double_speed = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        reset_values();
        check("rcode", right_gain, 8'hcf);
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        reset = 1'b1;
        double_speed = 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        reset_values();
        mute_bits();
        gain_codes();
        analog_fields();
        fade_steps();
        reset_again();
        test_done();
    end

    // Whole run is about 1200 cycles; allow several times that
    initial begin
        #300us;
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
